// ===== src/abx_exec.sv
// execution unit for add, and, clear, bit set/clear and bit-test-skip instructions
// Operation
// - add_literal_op adds an 8-bit literal to the accumulator, keeps the sum there and updates carry, half carry, zero.
// - and_file_op ands the accumulator with the addressed file register to the chosen destination, only zero changes.
// - destination bit 0 sends the result to the accumulator, 1 sends it back to the file register.
// - add_file_op adds accumulator and file register to the chosen destination and updates carry, half carry, zero.
// - clear_file_bit_op clears one indexed bit of the file register, nothing else changes.
// - set_file_bit_op sets one indexed bit of the file register, nothing else changes.
// - and_literal_op ands the accumulator with an 8-bit literal into the accumulator, only zero changes.
// - skip_if_bit_one_op discards the next instruction as a no-op when the tested bit is one.
// - skip_if_bit_zero_op discards the next instruction as a no-op when the tested bit is zero.
// - zero_file_op loads zero into the file register and sets the zero flag.
// - an instruction cycle is four oscillator periods, and a taken skip adds a no-op cycle.
// - read-modify-write on a port register reads the pin levels instead of the output latch.
module abx_exec #(
  parameter int BANK_W = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic instrValid,
  input wire logic [13:0] instrWord,
  input wire logic [BANK_W-1:0] bankSel,
  input wire logic [7:0] fileLatch,
  input wire logic [7:0] portPins,
  input wire logic fileIsPort,
  output logic [BANK_W+6:0] readAddr,
  output abx_pkg::abx_fwrite_t fileWrite,
  output logic [7:0] accOut,
  output abx_pkg::abx_flags_t flagsOut,
  output logic instrDone,
  output logic squashNext
);
  // oscillator phase counter, one instruction per four periods
  logic [1:0] phase_q;
  wire cycleEnd = clkEn && (phase_q == abx_pkg::PHASE_LAST);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) phase_q <= 2'h0;
    else if (clkEn) phase_q <= phase_q + 2'h1;
  end

  // instruction decode
  wire isAddFile = instrWord[13:8] == abx_pkg::OP_ADD_FILE;
  wire isAndFile = instrWord[13:8] == abx_pkg::OP_AND_FILE;
  wire isZeroFile = instrWord[13:7] == abx_pkg::OP_ZERO_FILE;
  wire isClrBit = instrWord[13:10] == abx_pkg::OP_CLR_BIT;
  wire isSetBit = instrWord[13:10] == abx_pkg::OP_SET_BIT;
  wire isSkipZero = instrWord[13:10] == abx_pkg::OP_SKIP_ZERO;
  wire isSkipOne = instrWord[13:10] == abx_pkg::OP_SKIP_ONE;
  wire isAddLit = instrWord[13:9] == abx_pkg::OP_ADD_LIT;
  wire isAndLit = instrWord[13:8] == abx_pkg::OP_AND_LIT;
  wire destFile = instrWord[abx_pkg::DEST_BIT];
  wire [2:0] bitIdx = instrWord[abx_pkg::BIT_IDX_LSB +: 3];
  wire [7:0] literal = instrWord[7:0];

  // full data address from bank and operand
  assign readAddr = {bankSel, instrWord[6:0]};

  // port registers modify from the pins, not the latch
  wire [7:0] fileVal = fileIsPort ? portPins : fileLatch;

  // state
  abx_pkg::abx_state_t state_q, state_d;
  logic [7:0] acc_q, acc_d;
  abx_pkg::abx_flags_t flags_q, flags_d;
  abx_pkg::abx_fwrite_t fw_q, fw_d;

  function automatic logic [7:0] bitMask(input logic [2:0] idx);
    bitMask = 8'h01 << idx;
  endfunction

  // adder shared by both add forms
  wire [7:0] addOperand = isAddLit ? literal : fileVal;
  wire [8:0] sum = {1'b0, acc_q} + {1'b0, addOperand};
  wire [4:0] lowSum = {1'b0, acc_q[3:0]} + {1'b0, addOperand[3:0]};
  wire [7:0] andResult = acc_q & (isAndLit ? literal : fileVal);
  wire testedBit = fileVal[bitIdx];
  wire skipTaken = (isSkipOne && testedBit) || (isSkipZero && !testedBit);
  wire inExec = state_q == abx_pkg::ST_EXEC;
  wire doExec = cycleEnd && inExec && instrValid;

  // next-state, accumulator, flags and file write
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    flags_d = flags_q;
    fw_d = '0;
    fw_d.addr = readAddr;
    if (cycleEnd) begin
      case (state_q)
        abx_pkg::ST_EXEC: begin
          if (instrValid) begin
            if (isAddLit) begin
              acc_d = sum[7:0];
              flags_d = '{carry: sum[8], halfCarry: lowSum[4], zero: sum[7:0] == 8'h00};
            end else if (isAndLit) begin
              acc_d = andResult;
              flags_d.zero = andResult == 8'h00;
            end else if (isAddFile || isAndFile) begin
              fw_d.data = isAddFile ? sum[7:0] : andResult;
              if (destFile) fw_d.en = 1'b1;
              else acc_d = fw_d.data;
              flags_d.zero = fw_d.data == 8'h00;
              if (isAddFile) begin
                flags_d.carry = sum[8];
                flags_d.halfCarry = lowSum[4];
              end
            end else if (isZeroFile) begin
              fw_d.en = 1'b1;
              fw_d.data = 8'h00;
              flags_d.zero = 1'b1;
            end else if (isClrBit) begin
              fw_d.en = 1'b1;
              fw_d.data = fileVal & ~bitMask(bitIdx);
            end else if (isSetBit) begin
              fw_d.en = 1'b1;
              fw_d.data = fileVal | bitMask(bitIdx);
            end
            if (skipTaken) state_d = abx_pkg::ST_NOP;
          end
        end
        abx_pkg::ST_NOP: state_d = abx_pkg::ST_EXEC;
        default: state_d = abx_pkg::ST_EXEC;
      endcase
    end
  end

  // registers; fileWrite, accOut and flagsOut come straight from flops, instrDone and squashNext are combinational
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= abx_pkg::ST_EXEC;
      acc_q <= abx_pkg::ACC_RESET;
      flags_q <= '0;
      fw_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      fw_q <= fw_d;
    end
  end

  assign fileWrite = fw_q;
  assign accOut = acc_q;
  assign flagsOut = flags_q;
  // one instruction retires per cycle end; the squashed slot is the no-op
  assign instrDone = doExec;
  assign squashNext = doExec && skipTaken;

  // checks; expectations rebuilt from sampled operands so a broken adder cannot hide; bit checks reuse bitMask
  // three quiet edges follow every cycle end, however long the enable stays low
  a_phase_period: assert property (@(posedge clock) disable iff (!resetn)
    cycleEnd |=> !cycleEnd [*3]) else $error("cycle end off phase");
  // a low enable must freeze accumulator, flags, state and phase count
  a_enable_hold: assert property (@(posedge clock) disable iff (!resetn)
    !clkEn |=> acc_q == $past(acc_q) && flags_q == $past(flags_q) && phase_q == $past(phase_q)
      && state_q == $past(state_q)) else $error("state moved while disabled");

  // literal forms
  a_add_lit_sum: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isAddLit |=> acc_q == 8'($past(acc_q) + $past(literal)) && flags_q.zero == (acc_q == 8'h00)
      && flags_q.carry == (({1'b0, $past(acc_q)} + {1'b0, $past(literal)}) > 9'h0ff))
    else $error("literal add wrong");
  a_lit_half: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isAddLit |=>
      flags_q.halfCarry == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(literal[3:0])}) > 5'h0f))
    else $error("literal half carry wrong");
  a_and_lit_zero: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isAndLit |=> acc_q == ($past(acc_q) & $past(literal)) && flags_q.zero == (acc_q == 8'h00)
      && flags_q.carry == $past(flags_q.carry) && flags_q.halfCarry == $past(flags_q.halfCarry))
    else $error("literal and wrong");

  // file forms and their destination
  a_dest_file: assert property (@(posedge clock) disable iff (!resetn)
    doExec && (isAddFile || isAndFile) && destFile |=> fileWrite.en && acc_q == $past(acc_q))
    else $error("file destination wrong");
  a_dest_acc: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isAddFile && !destFile |=> !fileWrite.en && acc_q == 8'($past(acc_q) + $past(fileVal)))
    else $error("accumulator destination wrong");
  a_and_file_flags: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isAndFile |=> flags_q.zero == (($past(acc_q) & $past(fileVal)) == 8'h00)
      && flags_q.carry == $past(flags_q.carry) && flags_q.halfCarry == $past(flags_q.halfCarry))
    else $error("file and flags wrong");
  a_add_file_half: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isAddFile |=>
      flags_q.halfCarry == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(fileVal[3:0])}) > 5'h0f)
      && flags_q.carry == (({1'b0, $past(acc_q)} + {1'b0, $past(fileVal)}) > 9'h0ff))
    else $error("file add flags wrong");
  a_zero_file_set: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isZeroFile |=> flags_q.zero && fileWrite.en && fileWrite.data == 8'h00)
    else $error("zero file wrong");

  // bit forms leave every flag alone
  a_bit_clear: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isClrBit |=> fileWrite.data == ($past(fileVal) & ~bitMask($past(bitIdx)))
      && flags_q == $past(flags_q)) else $error("bit clear wrong");
  a_bit_set: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isSetBit |=> fileWrite.data == ($past(fileVal) | bitMask($past(bitIdx)))
      && flags_q == $past(flags_q)) else $error("bit set wrong");

  // a taken skip squashes the whole next slot, a kept one squashes nothing
  a_skip_nop: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isSkipOne && fileVal[bitIdx] |-> squashNext ##1 (!instrDone [*4]))
    else $error("skip slot executed");
  a_skip_zero: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isSkipZero && !fileVal[bitIdx] |-> squashNext ##1 (!instrDone [*4]))
    else $error("clear skip missed");
  a_skip_kept: assert property (@(posedge clock) disable iff (!resetn)
    doExec && ((isSkipOne && !fileVal[bitIdx]) || (isSkipZero && fileVal[bitIdx])) |-> !squashNext)
    else $error("skip taken wrongly");
  a_skip_flags: assert property (@(posedge clock) disable iff (!resetn)
    doExec && (isSkipOne || isSkipZero) |=> flags_q == $past(flags_q) && acc_q == $past(acc_q))
    else $error("skip changed state");

  // read-modify-write of a port must start from the pins
  a_port_read: assert property (@(posedge clock) disable iff (!resetn)
    doExec && isClrBit && fileIsPort |=> fileWrite.data == ($past(portPins) & ~bitMask($past(bitIdx))))
    else $error("port latch used");
  // the written address carries the bank
  a_bank_addr: assert property (@(posedge clock) disable iff (!resetn)
    doExec && (isZeroFile || isClrBit || isSetBit) |=>
      fileWrite.addr == {$past(bankSel), $past(instrWord[6:0])})
    else $error("bank missing");

  // main scenarios
  c_skip_taken: cover property (@(posedge clock) disable iff (!resetn) squashNext);
  c_add_carry: cover property (@(posedge clock) disable iff (!resetn) doExec && isAddFile && sum[8]);
  c_port_rmw: cover property (@(posedge clock) disable iff (!resetn) doExec && isClrBit && fileIsPort);
  c_dest_acc: cover property (@(posedge clock) disable iff (!resetn) doExec && isAddFile && !destFile);
  c_enable_hold: cover property (@(posedge clock) disable iff (!resetn)
    !clkEn && instrValid && phase_q == abx_pkg::PHASE_LAST);
endmodule

// ===== src/abx_pkg.sv
// package for the bit and arithmetic instruction execution block
package abx_pkg;
  // opcode encodings of the 14-bit instruction word
  localparam logic [5:0] OP_ADD_FILE = 6'h07;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [6:0] OP_ZERO_FILE = 7'h03;
  localparam logic [3:0] OP_CLR_BIT = 4'h4;
  localparam logic [3:0] OP_SET_BIT = 4'h5;
  localparam logic [3:0] OP_SKIP_ZERO = 4'h6;
  localparam logic [3:0] OP_SKIP_ONE = 4'h7;
  localparam logic [4:0] OP_ADD_LIT = 5'h1f;
  localparam logic [5:0] OP_AND_LIT = 6'h39;
  // instruction word field positions
  localparam int DEST_BIT = 7;
  localparam int BIT_IDX_LSB = 7;
  // oscillator periods per instruction cycle
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [1:0] BANK_RESET = 2'h0;

  // flags carried together
  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic zero;
  } abx_flags_t;

  // file-space write request
  typedef struct packed {
    logic en;
    logic [8:0] addr;
    logic [7:0] data;
  } abx_fwrite_t;

  // execution state, one-hot
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_NOP = 2'b10
  } abx_state_t;
endpackage

// ===== test/abx_file_model.sv
// file register space and port pins facing the execution block
module abx_file_model #(
  parameter logic [8:0] PORT_ADDR = 9'h005
) (
  input wire logic clock,
  input wire logic [8:0] readAddr,
  input wire abx_pkg::abx_fwrite_t fileWrite,
  output logic [7:0] fileLatch,
  output logic [7:0] portPins,
  output logic fileIsPort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [512];
  logic [7:0] pins = 8'h00;
  // combinational read; pins differ from the latch to expose a latch read
  assign fileLatch = mem[readAddr];
  assign portPins = pins;
  assign fileIsPort = readAddr == PORT_ADDR;
  // a standing request rewrites the same byte, which is harmless
  always @(posedge clock) begin
    if (fileWrite.en === 1'b1) begin
      mem[fileWrite.addr] <= fileWrite.data;
    end
  end
endmodule

// ===== test/test_alu_bit_instr_exec.sv
// self-checking bench for the execution block
module test_alu_bit_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic instrValid = 1'b0;
  logic [13:0] instrWord = 14'h0000;
  logic [1:0] bankSel = 2'h0;
  logic [7:0] fileLatch, portPins, accOut;
  logic fileIsPort, instrDone, squashNext, sq;
  logic [8:0] readAddr;
  abx_pkg::abx_fwrite_t fileWrite;
  abx_pkg::abx_flags_t flagsOut;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  abx_exec #(.BANK_W(2)) abx_exec_i (.clock(clock), .resetn(resetn), .clkEn(clkEn),
    .instrValid(instrValid), .instrWord(instrWord), .bankSel(bankSel), .fileLatch(fileLatch),
    .portPins(portPins), .fileIsPort(fileIsPort), .readAddr(readAddr), .fileWrite(fileWrite),
    .accOut(accOut), .flagsOut(flagsOut), .instrDone(instrDone), .squashNext(squashNext));
  abx_file_model abx_file_model_i (.clock(clock), .readAddr(readAddr), .fileWrite(fileWrite),
    .fileLatch(fileLatch), .portPins(portPins), .fileIsPort(fileIsPort));

  // clock and a hang limit
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chkW(input abx_pkg::abx_fwrite_t g, input abx_pkg::abx_fwrite_t e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected write at %0t: %h not %h", $time, g, e);
    end
  endtask

  task automatic chkR(input logic [10:0] e);
    total_checks++;
    if ({accOut, flagsOut} !== e) begin
      err_count++;
      $display("unexpected acc/flags at %0t: %h not %h", $time, {accOut, flagsOut}, e);
    end
  endtask

  task automatic chkB(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected flag bit at %0t: %b not %b", $time, g, e);
    end
  endtask

  // one instruction, released after its executing edge
  task automatic exec(input logic [13:0] w);
    int n;
    @(posedge clock);
    #1;
    instrWord = w;
    instrValid = 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (instrDone !== 1'b1 && n < 8);
    chkB(instrDone, 1'b1);
    sq = squashNext;
    @(posedge clock);
    #1;
    instrValid = 1'b0;
  endtask

  task automatic t_literal;
    exec({abx_pkg::OP_ADD_LIT, 9'h08f});
    chkR({8'h8f, 3'b000});
    exec({abx_pkg::OP_ADD_LIT, 9'h075});
    chkR({8'h04, 3'b110});
    exec({abx_pkg::OP_AND_LIT, 8'h03});
    chkR({8'h00, 3'b111});
  endtask

  // bank 2 targets; flags follow each result
  task automatic t_file;
    bankSel = 2'h2;
    abx_file_model_i.mem[9'h125] = 8'hf8;
    abx_file_model_i.mem[9'h126] = 8'h0c;
    exec({abx_pkg::OP_ADD_LIT, 9'h008});
    chkR({8'h08, 3'b000});
    exec({abx_pkg::OP_ADD_FILE, 8'ha5});
    chkW(fileWrite, {1'b1, 9'h125, 8'h00});
    chkR({8'h08, 3'b111});
    exec({abx_pkg::OP_AND_FILE, 8'h26});
    chkR({8'h08, 3'b110});
    exec({abx_pkg::OP_AND_FILE, 8'ha6});
    chkW(fileWrite, {1'b1, 9'h126, 8'h08});
    exec({abx_pkg::OP_ADD_FILE, 8'h26});
    chkR({8'h10, 3'b010});
    exec({abx_pkg::OP_ZERO_FILE, 7'h27});
    chkW(fileWrite, {1'b1, 9'h127, 8'h00});
    chkR({8'h10, 3'b011});
  endtask

  // every bit index, set and clear, flags left alone
  task automatic t_bits;
    bankSel = 2'h0;
    for (int b = 0; b < 8; b++) begin
      abx_file_model_i.mem[9'h010 + 9'(b)] = 8'h00;
      exec({abx_pkg::OP_SET_BIT, 3'(b), 7'h10 + 7'(b)});
      chkW(fileWrite, {1'b1, 9'h010 + 9'(b), 8'h01 << b});
      abx_file_model_i.mem[9'h020 + 9'(b)] = 8'hff;
      exec({abx_pkg::OP_CLR_BIT, 3'(b), 7'h20 + 7'(b)});
      chkW(fileWrite, {1'b1, 9'h020 + 9'(b), ~(8'h01 << b)});
    end
    chkR({8'h10, 3'b011});
  endtask

  // both tests on both bit values; a taken skip discards the next add
  task automatic t_skip;
    logic taken;
    for (int k = 0; k < 4; k++) begin
      taken = (k == 0) || (k == 3);
      abx_file_model_i.mem[9'h030 + 9'(k)] = k[0] ? 8'h20 : 8'hdf;
      exec({k[1] ? abx_pkg::OP_SKIP_ONE : abx_pkg::OP_SKIP_ZERO, 3'h5, 7'h30 + 7'(k)});
      chkB(sq, taken);
      if (taken) begin
        @(posedge clock);
        #1;
        instrWord = {abx_pkg::OP_ADD_LIT, 9'h001};
        instrValid = 1'b1;
        repeat (3) begin
          @(negedge clock);
          chkB(instrDone, 1'b0);
        end
        @(posedge clock);
        #1;
        instrValid = 1'b0;
      end
      chkR({8'h10, 3'b011});
    end
  endtask

  // modify of a port takes the pins, not the latch
  task automatic t_port;
    abx_file_model_i.mem[9'h005] = 8'hff;
    abx_file_model_i.pins = 8'h0f;
    exec({abx_pkg::OP_CLR_BIT, 3'h0, 7'h05});
    chkW(fileWrite, {1'b1, 9'h005, 8'h0e});
  endtask

  // enable dropped in the executing phase holds the instruction back; entered at phase 0
  task automatic t_hold;
    @(posedge clock);
    #1;
    instrWord = {abx_pkg::OP_ADD_LIT, 9'h0f0};
    instrValid = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    clkEn = 1'b0;
    repeat (5) begin
      @(negedge clock);
      chkB(instrDone, 1'b0);
    end
    chkR({8'h10, 3'b011});
    @(posedge clock);
    #1;
    clkEn = 1'b1;
    @(negedge clock);
    chkB(instrDone, 1'b1);
    @(posedge clock);
    #1;
    instrValid = 1'b0;
    chkR({8'h00, 3'b101});
  endtask

  // reset in mid-run clears accumulator, flags and the write request, then restarts the cycle
  task automatic t_reset;
    @(posedge clock);
    #1;
    resetn = 1'b0;
    @(negedge clock);
    chkR({abx_pkg::ACC_RESET, 3'b000});
    chkW(fileWrite, '0);
    @(posedge clock);
    #1;
    resetn = 1'b1;
    exec({abx_pkg::OP_ADD_LIT, 9'h0ff});
    chkR({8'hff, 3'b000});
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_literal();
    t_file();
    t_bits();
    t_skip();
    t_hold();
    t_port();
    t_reset();
    conclude();
  end
endmodule
